/* include/mdd_pkg.sv */
// Constants, register map and field layout for the mirror driver diagnostics block.
//
// Operation
// - Bit 3 of the diag register turns the high-side source on or off and reads back.
// - Bit 2 of the diag register turns the low-side sink on or off and reads back.
// - The source feeds the mirror sense pin and the sink the mirror resistor pin.
// - Bit 1 is a read-only, unlatched open/short flag showing the live comparator result.
// - An over-current disables the driver and sets bit 0; bit 0 stays 1 after the over-current ends, until cleared.
// - The over-current flag clears only on a write of 1 to bit 0; a 0 leaves it alone.
// - Bits 7 to 4 of the diag register are unimplemented, read as zero and ignore writes.
// - A short to ground above the protection threshold turns the output stage off.
// - The over-current flag, kept in the diag register, also shows in the global status.
// - The driver enable is held off while the over-current flag is set.
package mdd_pkg;

   // Bus geometry.
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;

   // Register byte addresses.
   localparam logic [ADDR_W-1:0] ADDR_MIRROR_DRIVER_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_GLOBAL_IRQ_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_GLOBAL_IRQ_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_MIRROR_DIAG_STATUS = 8'h0c;

   // Driver control register fields.
   localparam int unsigned CTRL_EN_BIT = 7;
   localparam int unsigned CTRL_DSC_BIT = 6;
   localparam int unsigned CTRL_DAC_LSB = 0;
   localparam int unsigned DAC_W = 6;

   // Diagnostic register fields.
   localparam int unsigned DIAG_SRC_HIGH_BIT = 3;
   localparam int unsigned DIAG_SINK_LOW_BIT = 2;
   localparam int unsigned DIAG_OSF_BIT = 1;
   localparam int unsigned DIAG_OCIF_BIT = 0;

   // Interrupt status and mask fields.
   localparam int unsigned IRQ_OC_BIT = 0;
   localparam int unsigned IRQ_OSF_BIT = 1;
   localparam int unsigned IRQ_W = 2;

   // Reset values.
   localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   // Synchroniser depth for the analog comparator inputs.
   localparam int unsigned SYNC_STAGES = 2;

endpackage

/* core/mdd_sync.sv */
// Two-stage synchroniser for the comparator levels that come from the analog side.
`timescale 1ns/1ps
module mdd_sync #(
   parameter int unsigned WIDTH = 2
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Asynchronous levels in, synchronised levels out.
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // The first stage is read only by the second, so metastability has a full cycle to settle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

/* core/mdd_core.sv */
// Mirror driver control and diagnostics register bank with a classic Wishbone slave port.
`timescale 1ns/1ps
module mdd_core
   import mdd_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DATA_W-1:0] wb_dat_i,
   output logic [DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Analog comparator results, asynchronous to clk_i.
   input wire logic open_short_cmp_i,
   input wire logic overcurrent_cmp_i,
   // Diagnostic current source on the mirror sense pin and sink on the mirror resistor pin.
   output logic diag_source_high_en_o,
   output logic diag_sink_low_en_o,
   // Driver output stage controls.
   output logic mirror_driver_en_o,
   output logic mirror_discharge_en_o,
   output logic [DAC_W-1:0] mirror_dac_o,
   // Level interrupt.
   output logic irq_o
);

   // Synchronised comparator levels.
   logic [1:0] cmp_sync;
   logic open_short_flag;
   logic overcurrent_live;

   // Bus state.
   logic ack_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic bus_req;
   logic wr_commit;
   logic rd_commit;
   logic lane0_wr;

   // Register state.
   logic ctrl_en_q;
   logic ctrl_dsc_q;
   logic [DAC_W-1:0] ctrl_dac_q;
   logic src_high_q;
   logic sink_low_q;
   logic overcurrent_irq_flag_q;
   logic osf_sticky_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic osf_prev_q;
   logic osf_rise;

   // Output registers.
   logic drv_en_q;
   logic irq_q;

   // Byte view of the live registers, shared by the read mux and the interrupt logic.
   logic [REG_W-1:0] ctrl_view;
   logic [REG_W-1:0] diag_view;
   logic [IRQ_W-1:0] irq_status_view;

   // Zero-extend an 8-bit register into the 32-bit data word.
   function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
      widen = {{(DATA_W-REG_W){1'b0}}, v};
   endfunction

   // True when the bus address equals the given register offset; used for both writes and reads.
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // Both comparator outputs come from the analog domain and pass two flip-flops.
   mdd_sync #(
      .WIDTH(2)
   ) u_cmp_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({overcurrent_cmp_i, open_short_cmp_i}),
      .sync_o(cmp_sync)
   );

   assign open_short_flag = cmp_sync[0];
   assign overcurrent_live = cmp_sync[1];

   // Bus request decode. Writes and read side effects take place at the edge where the
   // master sees ack high, so a held request is acted on exactly once.
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_commit = bus_req & ack_q & wb_we_i;
   assign rd_commit = bus_req & ack_q & ~wb_we_i;
   // Every register sits in the low byte lane, at most eight bits wide (the interrupt registers two); other lanes are ignored.
   assign lane0_wr = wr_commit & wb_sel_i[0];

   // Register views as software sees them.
   always_comb begin
      ctrl_view = '0;
      ctrl_view[CTRL_EN_BIT] = ctrl_en_q;
      ctrl_view[CTRL_DSC_BIT] = ctrl_dsc_q;
      ctrl_view[CTRL_DAC_LSB +: DAC_W] = ctrl_dac_q;
      // Upper nibble stays zero: those bits have no storage at all.
      diag_view = '0;
      diag_view[DIAG_SRC_HIGH_BIT] = src_high_q;
      diag_view[DIAG_SINK_LOW_BIT] = sink_low_q;
      // The open/short bit is the live comparator level, never a stored copy.
      diag_view[DIAG_OSF_BIT] = open_short_flag;
      diag_view[DIAG_OCIF_BIT] = overcurrent_irq_flag_q;
      irq_status_view = '0;
      // The global status shows the very same flip-flop as the diagnostic register.
      irq_status_view[IRQ_OC_BIT] = overcurrent_irq_flag_q;
      irq_status_view[IRQ_OSF_BIT] = osf_sticky_q;
   end

   // Read data mux; unmapped addresses answer with zero.
   always_comb begin
      unique case (wb_adr_i)
         ADDR_MIRROR_DRIVER_CTRL: rdata_d = widen(ctrl_view);
         ADDR_GLOBAL_IRQ_STATUS: rdata_d = widen({{(REG_W-IRQ_W){1'b0}}, irq_status_view});
         ADDR_GLOBAL_IRQ_MASK: rdata_d = widen({{(REG_W-IRQ_W){1'b0}}, irq_mask_q});
         ADDR_MIRROR_DIAG_STATUS: rdata_d = widen(diag_view);
         default: rdata_d = DATA_ZERO;
      endcase
   end

   // Acknowledge one cycle after the request is seen, then drop for a cycle.
   // Read data is captured together with ack and stands for that ack cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= DATA_ZERO;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (bus_req & ~ack_q & ~wb_we_i) begin
            rdata_q <= rdata_d;
         end else if (~bus_req | ack_q) begin
            rdata_q <= DATA_ZERO;
         end
      end
   end

   // Driver control register. An over-current clears the stored enable, and while the
   // flag stays set any attempt to write the enable back to 1 is dropped.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_en_q <= CTRL_RESET[CTRL_EN_BIT];
         ctrl_dsc_q <= CTRL_RESET[CTRL_DSC_BIT];
         ctrl_dac_q <= CTRL_RESET[CTRL_DAC_LSB +: DAC_W];
      end else begin
         if (lane0_wr && hit(wb_adr_i, ADDR_MIRROR_DRIVER_CTRL)) begin
            ctrl_dsc_q <= wb_dat_i[CTRL_DSC_BIT];
            ctrl_dac_q <= wb_dat_i[CTRL_DAC_LSB +: DAC_W];
            ctrl_en_q <= wb_dat_i[CTRL_EN_BIT] & ~overcurrent_irq_flag_q;
         end
         if (overcurrent_live) begin
            ctrl_en_q <= 1'b0;
         end
      end
   end

   // Diagnostic source and sink enables: plain read/write bits that go straight to the
   // current source on the sense pin and the sink on the resistor pin.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_high_q <= 1'b0;
         sink_low_q <= 1'b0;
      end else if (lane0_wr && hit(wb_adr_i, ADDR_MIRROR_DIAG_STATUS)) begin
         src_high_q <= wb_dat_i[DIAG_SRC_HIGH_BIT];
         sink_low_q <= wb_dat_i[DIAG_SINK_LOW_BIT];
      end
   end

   // Over-current flag: set by the comparator, cleared only by writing 1 to bit 0.
   // The set is tested last so an over-current in the clearing cycle is not lost,
   // and a fault that is still present simply keeps the flag up.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overcurrent_irq_flag_q <= 1'b0;
      end else begin
         if (lane0_wr && hit(wb_adr_i, ADDR_MIRROR_DIAG_STATUS)
               && wb_dat_i[DIAG_OCIF_BIT]) begin
            overcurrent_irq_flag_q <= 1'b0;
         end
         if (overcurrent_live) begin
            overcurrent_irq_flag_q <= 1'b1;
         end
      end
   end

   // Open/short rising-edge detector on the synchronised comparator level.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osf_prev_q <= 1'b0;
      end else begin
         osf_prev_q <= open_short_flag;
      end
   end

   assign osf_rise = open_short_flag & ~osf_prev_q;

   // Sticky open/short event, cleared by a read of the global status register.
   // The over-current bit of that register is not touched by the read: it has one
   // home, the diagnostic register, and is cleared only there.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osf_sticky_q <= 1'b0;
      end else begin
         if (rd_commit && hit(wb_adr_i, ADDR_GLOBAL_IRQ_STATUS)) begin
            osf_sticky_q <= 1'b0;
         end
         if (osf_rise) begin
            osf_sticky_q <= 1'b1;
         end
      end
   end

   // Interrupt mask, same layout as the status register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_q <= IRQ_MASK_RESET;
      end else if (lane0_wr && hit(wb_adr_i, ADDR_GLOBAL_IRQ_MASK)) begin
         irq_mask_q <= wb_dat_i[IRQ_W-1:0];
      end
   end

   // Interrupt level: high while any unmasked status bit is set, one cycle behind it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_status_view & irq_mask_q);
      end
   end

   // Driver enable seen by the output stage. The live comparator is included too so the
   // stage drops on the first synchronised cycle of a fault, not one cycle later.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drv_en_q <= 1'b0;
      end else begin
         drv_en_q <= ctrl_en_q & ~overcurrent_irq_flag_q & ~overcurrent_live;
      end
   end

   // Outputs, all straight from flip-flops. The diagnostic enables are not forced off
   // while the driver runs; software must discard results taken then.
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign diag_source_high_en_o = src_high_q;
   assign diag_sink_low_en_o = sink_low_q;
   assign mirror_driver_en_o = drv_en_q;
   assign mirror_discharge_en_o = ctrl_dsc_q;
   assign mirror_dac_o = ctrl_dac_q;
   assign irq_o = irq_q;

endmodule

/* tb/mdd_core_properties.sv */
// Port-level checker for the diagnostics register bank.
`timescale 1ns/1ps
module mdd_core_properties
   import mdd_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DATA_W-1:0] wb_dat_i,
   input wire logic [DATA_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Analog side and outputs.
   input wire logic open_short_cmp_i,
   input wire logic overcurrent_cmp_i,
   input wire logic diag_source_high_en_o,
   input wire logic diag_sink_low_en_o,
   input wire logic mirror_driver_en_o,
   input wire logic mirror_discharge_en_o,
   input wire logic [DAC_W-1:0] mirror_dac_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic req;
   logic wr_diag;
   logic wr_ctrl;
   // Writes are held until ack, so a register change must trail one by a few edges.
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_diag = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADDR_MIRROR_DIAG_STATUS);
   assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADDR_MIRROR_DRIVER_CTRL);
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_after_req: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(req))
      else $error("ack without request");
   a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == DATA_ZERO)
      else $error("read data outside ack");
   a_diag_upper_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == ADDR_MIRROR_DIAG_STATUS |-> wb_dat_o[31:4] == 28'h0)
      else $error("unused diag bits not zero");
   a_diag_by_write: assert property (
      $changed({diag_source_high_en_o, diag_sink_low_en_o})
      |-> $past(wr_diag) || $past(wr_diag, 2) || $past(wr_diag, 3))
      else $error("diag enable moved without write");
   a_oc_cuts_driver: assert property (
      overcurrent_cmp_i [*3] |=> !mirror_driver_en_o)
      else $error("driver on during over-current");
   a_enable_by_write: assert property (
      $rose(mirror_driver_en_o) |-> $past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
      else $error("driver enabled without write");
   c_diag_write: cover property (wr_diag && wb_ack_o);
   c_oc_trip: cover property ($fell(mirror_driver_en_o));
   c_irq_raise: cover property ($rose(irq_o));
endmodule
bind mdd_core mdd_core_properties i_mdd_core_properties (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .open_short_cmp_i, .overcurrent_cmp_i, .diag_source_high_en_o, .diag_sink_low_en_o,
   .mirror_driver_en_o, .mirror_discharge_en_o, .mirror_dac_o, .irq_o);

/* tb/mdd_load.sv */
// Behavioural mirror load seen through the sense and resistor pins.
`timescale 1ns/1ps
module mdd_load (
   // Clock and enables.
   input wire logic clk_i,
   input wire logic src_en_i,
   input wire logic sink_en_i,
   input wire logic drv_en_i,
   // Fault: 0 normal, 1 short to supply, 2 open, 3 hard short to ground.
   input wire logic [1:0] fault_i,
   // Comparator levels.
   output logic osf_o,
   output logic oc_o
);
   logic junk_q = 1'b0;
   // Unless exactly one of source and sink is on, the comparator means nothing, so it wanders.
   always @(posedge clk_i) junk_q <= ~junk_q;
   // Source lifts the sense pin, sink pulls the resistor pin.
   always_comb begin
      if (src_en_i ^ sink_en_i)
         osf_o = (fault_i == 2'd1) || (fault_i == 2'd2 && src_en_i);
      else
         osf_o = junk_q;
      oc_o = drv_en_i && fault_i == 2'd3;
   end
endmodule

/* tb/tb_mdd_core.sv */
// Self-checking bench for the diagnostics register bank.
`timescale 1ns/1ps
module tb_mdd_core
   import mdd_pkg::*;
();
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [ADDR_W-1:0] adr = '0;
   logic [3:0] sel = '0;
   logic [DATA_W-1:0] wdat = '0;
   logic [DATA_W-1:0] rdat;
   logic ack, osf, oc, src, sink, drv, dsc, irq;
   logic [DAC_W-1:0] dac;
   logic [1:0] fault = 2'd0;
   integer seed = 32'hd98e;
   logic [DATA_W-1:0] exp_q[$];
   logic [DATA_W-1:0] msk_q[$];
   int n_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   always #25 clk_i = ~clk_i;
   mdd_core i_mdd_core (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .open_short_cmp_i(osf), .overcurrent_cmp_i(oc), .diag_source_high_en_o(src),
      .diag_sink_low_en_o(sink), .mirror_driver_en_o(drv), .mirror_discharge_en_o(dsc),
      .mirror_dac_o(dac), .irq_o(irq));
   mdd_load i_mdd_load (.clk_i, .src_en_i(src), .sink_en_i(sink), .drv_en_i(drv),
      .fault_i(fault), .osf_o(osf), .oc_o(oc));
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
      n_checks++;
      if (got !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, e);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // One classic cycle; the request stands until ack is sampled high.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // A read notes its expected word and mask before it goes out.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(1'b0, a, '0, 4'hf);
   endtask
   // Read data is compared with the oldest note when the answer arrives.
   always @(posedge clk_i)
      if (ack === 1'b1 && cyc && !we && exp_q.size() > 0)
         check(rdat & msk_q.pop_front(), exp_q.pop_front());
   // A hang is cut short well beyond the expected run.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      logic [7:0] r;
      logic [31:0] m;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADDR_MIRROR_DIAG_STATUS, 32'h0, 32'hfffffffd);
      rd(ADDR_MIRROR_DRIVER_CTRL, 32'h0, '1);
      rd(8'h20, 32'h0, '1);
      $display("test reset done");
      // Faults 0 to 2 against the sink-only, source-only and both-on settings, driver held off so results are valid.
      for (int f = 0; f < 3; f++) begin
         for (int e = 1; e < 4; e++) begin
            fault <= f[1:0];
            r = 8'($random(seed));
            m = (e == 3) ? 32'hfffffffd : '1;
            bus(1'b1, ADDR_MIRROR_DIAG_STATUS, {24'h0, r[7:4], e[1:0], 2'b0}, 4'h1);
            repeat (4) @(posedge clk_i);
            check(32'(src), 32'(e[1]));
            check(32'(sink), 32'(e[0]));
            rd(ADDR_MIRROR_DIAG_STATUS,
               {28'h0, e[1:0], f == 1 || (f == 2 && e == 2), 1'b0} & m, m);
         end
      end
      bus(1'b1, ADDR_MIRROR_DIAG_STATUS, 32'h0, 4'h0);
      repeat (3) @(posedge clk_i);
      check(32'({src, sink}), 32'h3);
      bus(1'b1, ADDR_MIRROR_DIAG_STATUS, 32'h0, 4'h1);
      $display("test diag done");
      // A hard short trips the driver and the flag holds until written with 1.
      fault <= 2'd3;
      r = 8'($random(seed));
      bus(1'b1, ADDR_MIRROR_DRIVER_CTRL, {24'h0, 1'b1, r[6:0]}, 4'h1);
      repeat (6) @(posedge clk_i);
      check(32'({drv, dsc, dac}), 32'(r[6:0]));
      rd(ADDR_MIRROR_DIAG_STATUS, 32'h1, 32'hfffffffd);
      rd(ADDR_GLOBAL_IRQ_STATUS, 32'h1, 32'hfffffffd);
      bus(1'b1, ADDR_MIRROR_DIAG_STATUS, 32'h0, 4'h1);
      rd(ADDR_MIRROR_DIAG_STATUS, 32'h1, 32'hfffffffd);
      bus(1'b1, ADDR_MIRROR_DRIVER_CTRL, 32'h80, 4'h1);
      // The enable written while the flag stands must not be stored either.
      rd(ADDR_MIRROR_DRIVER_CTRL, 32'h0, '1);
      bus(1'b1, ADDR_GLOBAL_IRQ_MASK, 32'h1, 4'h1);
      repeat (4) @(posedge clk_i);
      check(32'({drv, irq}), 32'h1);
      bus(1'b1, ADDR_GLOBAL_IRQ_MASK, 32'h0, 4'h1);
      repeat (3) @(posedge clk_i);
      check(32'(irq), 32'h0);
      bus(1'b1, ADDR_GLOBAL_IRQ_MASK, 32'h1, 4'h1);
      fault <= 2'd0;
      bus(1'b1, ADDR_MIRROR_DIAG_STATUS, 32'h1, 4'h1);
      repeat (3) @(posedge clk_i);
      check(32'(irq), 32'h0);
      rd(ADDR_MIRROR_DIAG_STATUS, 32'h0, 32'hfffffffd);
      bus(1'b1, ADDR_MIRROR_DRIVER_CTRL, 32'h80, 4'h1);
      repeat (4) @(posedge clk_i);
      check(32'(drv), 32'h1);
      // Every noted read must have been answered and compared.
      check(32'(exp_q.size()), 32'h0);
      $display("test overcurrent done");
      finish_test();
   end
endmodule
